// file: cts_pkg.sv
// cts_pkg: constants shared by the cascade trigger synchroniser
// assumes a 125 MHz reference clock and a byte-level serial-bus framer outside
package cts_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam int MS_US = 1000;
   localparam int TRIG_PULSE_US = 10;
   // serial-bus framing
   localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
   localparam logic [15:0] CASCADE_REG_ADDR = 16'h0049;
   localparam logic [15:0] CASCADE_REG_COUNT = 16'h0004;
   localparam logic [7:0] CASCADE_BYTE_COUNT = 8'h08;
   localparam logic [15:0] PIN_REG_ADDR = 16'h0051;
   localparam logic [15:0] PIN_REG_COUNT = 16'h0002;
   localparam logic [7:0] PIN_BYTE_COUNT = 8'h04;
   localparam int HDR_LEN = 7;
   localparam int FRAME_MAX = 17;
   localparam int REPLY_LEN = 8;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   // data byte positions in cascade_settings (little-endian words)
   localparam int CS_ENABLE = 0;
   localparam int CS_ROLE = 1;
   localparam int CS_DELAY_LO = 2;
   localparam int CS_DELAY_HI = 3;
   localparam int CS_CYCLE_LO = 6;
   localparam int CS_CYCLE_HI = 7;
   // data byte positions in shared_pin_settings
   localparam int PS_OUT_FN = 0;
   localparam int PS_IN_FN = 1;
   localparam int PS_POLARITY = 2;
   localparam int PS_DIRECTION = 3;
   // field values
   localparam logic [7:0] ROLE_MASTER = 8'h01;
   localparam logic [7:0] OUT_FN_TRIGGER = 8'h03;
   localparam logic [7:0] IN_FN_TRIGGER = 8'h01;
   localparam logic [7:0] DIR_OUTPUT = 8'h00;
   localparam logic [7:0] DIR_INPUT = 8'h01;
   localparam logic [7:0] POL_LIGHT = 8'h00;
   // reset values
   localparam logic [63:0] CASCADE_RESET = 64'h0;
   localparam logic [31:0] PIN_RESET = 32'h0;

   typedef enum logic [1:0] {CTS_IDLE, CTS_DELAY, CTS_SCAN} cts_slave_t;

   function automatic logic [15:0] cts_crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : cts_crc_byte
endpackage : cts_pkg

// file: cts_sync.sv
// cts_sync: cascade trigger synchroniser with serial-bus register writes
// assumes rx bytes and the frame-end pulse come from a framer on ref_clk;
// the shared pin and scan_done may be asynchronous
//
// Contract
// [RULE1] cascade triggering runs only while the cascading enable is 1
// [RULE2] role 1 makes this unit master generating the cascade trigger
// [RULE3] role 0 makes this unit slave, scanning only after a trigger
// [RULE4] master repeats its trigger once per master cycle in milliseconds
// [RULE5] configurer sets master cycle to the sum of all unit scan times
// [RULE6] slave waits its trigger-to-scan delay in microseconds before scanning
// [RULE7] configurer sets third unit delay to first plus second scan times
// [RULE8] shared pin is driven when direction is 0, sampled when 1
// [RULE9] switching behaviour 0 selects light-switching polarity, both directions
// [RULE10] output function 3 drives the master trigger onto the shared pin
// [RULE11] input function 1 makes the shared pin the slave scan trigger
// [RULE12] host writes cascade settings at 0x49, four registers, eight bytes
// [RULE13] cascade write answered by station, function, start, count, checksum
// [RULE14] host writes shared-pin settings at 0x51, two registers, four bytes
// [RULE15] pin write answered by station, function, start, count, checksum
// [RULE16] slave runs one delayed scan per trigger edge, ignoring edges meanwhile
`timescale 1ns/1ps
module cts_sync
   import cts_pkg::*;
#(
   parameter logic [7:0] STATION = 8'h01,
   parameter int US_DIV = US_CYCLES,
   parameter int MS_DIV = MS_US
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // serial-bus byte stream in
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic rx_end,
   // serial-bus byte stream out
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   // shared digital pin
   input wire logic shared_digital_pin_in,
   output logic shared_digital_pin_out,
   output logic shared_digital_pin_oe,
   // scan control
   output logic scan_start,
   input wire logic scan_done,
   // settings readback
   output logic [63:0] cascade_settings,
   output logic [31:0] shared_pin_settings
);

   ////////////////////////////////////////////////////////////////////////////
   // frame reception
   logic [7:0] frame_mem [FRAME_MAX];
   logic [4:0] rx_cnt_reg;
   logic rx_over_reg;
   logic [15:0] rx_crc_reg;
   logic tx_busy_reg;
   logic [2:0] tx_idx_reg;
   logic [63:0] cascade_reg;
   logic [31:0] pin_reg;

   // frames arriving while a reply is still going out are dropped
   wire rx_take = rx_valid && !tx_busy_reg;
   wire [15:0] f_start = {frame_mem[2], frame_mem[3]};
   wire [15:0] f_count = {frame_mem[4], frame_mem[5]};
   wire hdr_ok = !rx_over_reg && rx_crc_reg == 16'h0000 && frame_mem[0] == STATION
                 && frame_mem[1] == FN_WRITE_MULTI;
   wire wr_cascade = rx_end && !tx_busy_reg && hdr_ok && f_start == CASCADE_REG_ADDR
                     && f_count == CASCADE_REG_COUNT && frame_mem[6] == CASCADE_BYTE_COUNT
                     && rx_cnt_reg == 5'(HDR_LEN + 10); // RULE12
   wire wr_pin = rx_end && !tx_busy_reg && hdr_ok && f_start == PIN_REG_ADDR
                 && f_count == PIN_REG_COUNT && frame_mem[6] == PIN_BYTE_COUNT
                 && rx_cnt_reg == 5'(HDR_LEN + 6); // RULE14

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_reg <= 5'h00;
         rx_over_reg <= 1'b0;
         rx_crc_reg <= CRC_INIT;
      end else if (rx_end) begin
         rx_cnt_reg <= 5'h00;
         rx_over_reg <= 1'b0;
         rx_crc_reg <= CRC_INIT;
      end else if (rx_take) begin
         rx_crc_reg <= cts_crc_byte(rx_crc_reg, rx_byte);
         if (rx_cnt_reg == 5'(FRAME_MAX)) begin
            rx_over_reg <= 1'b1;
         end else begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rx_take && rx_cnt_reg < 5'(FRAME_MAX)) begin
         frame_mem[rx_cnt_reg] <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings registers; data bytes stored in arrival order
   wire [63:0] cascade_next = {frame_mem[14], frame_mem[13], frame_mem[12], frame_mem[11],
                               frame_mem[10], frame_mem[9], frame_mem[8], frame_mem[7]};
   wire [31:0] pin_next = {frame_mem[10], frame_mem[9], frame_mem[8], frame_mem[7]};

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cascade_reg <= CASCADE_RESET;
         pin_reg <= PIN_RESET;
      end else begin
         if (wr_cascade) cascade_reg <= cascade_next; // RULE12
         if (wr_pin) pin_reg <= pin_next; // RULE14
      end
   end

   assign cascade_settings = cascade_reg;
   assign shared_pin_settings = pin_reg;

   ////////////////////////////////////////////////////////////////////////////
   // reply: echo station, function, start, count, then crc low and high
   // whole reply is built at frame end so tx_byte comes straight from a flop
   logic [63:0] rep_reg;
   logic [15:0] rep_crc;
   wire [31:0] rep_regs = wr_cascade ? {CASCADE_REG_ADDR, CASCADE_REG_COUNT}
                                     : {PIN_REG_ADDR, PIN_REG_COUNT};
   wire [47:0] rep_head = {STATION, FN_WRITE_MULTI, rep_regs};

   always_comb begin
      rep_crc = CRC_INIT;
      for (int i = 0; i < REPLY_LEN - 2; i++) begin
         rep_crc = cts_crc_byte(rep_crc, rep_head[47 - 8 * i -: 8]);
      end
   end

   wire tx_fire = tx_busy_reg && tx_ready;
   wire tx_last = tx_idx_reg == 3'(REPLY_LEN - 1);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_busy_reg <= 1'b0;
         tx_idx_reg <= 3'd0;
         rep_reg <= 64'h0;
      end else if (wr_cascade || wr_pin) begin
         tx_busy_reg <= 1'b1; // RULE13 RULE15
         tx_idx_reg <= 3'd0;
         rep_reg <= {rep_head, rep_crc[7:0], rep_crc[15:8]}; // RULE13 RULE15
      end else if (tx_fire) begin
         tx_idx_reg <= tx_last ? 3'd0 : tx_idx_reg + 3'd1;
         rep_reg <= {rep_reg[55:0], 8'h00};
         if (tx_last) tx_busy_reg <= 1'b0;
      end
   end

   assign tx_byte = rep_reg[63:56];
   assign tx_valid = tx_busy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // configuration decode
   wire casc_on = cascade_reg[8*CS_ENABLE +: 8] == 8'h01; // RULE1
   wire is_master = cascade_reg[8*CS_ROLE +: 8] == ROLE_MASTER; // RULE2 RULE3
   wire [15:0] delay_us = {cascade_reg[8*CS_DELAY_HI +: 8], cascade_reg[8*CS_DELAY_LO +: 8]};
   wire [15:0] cycle_ms = {cascade_reg[8*CS_CYCLE_HI +: 8], cascade_reg[8*CS_CYCLE_LO +: 8]};
   wire pin_drive = pin_reg[8*PS_DIRECTION +: 8] == DIR_OUTPUT; // RULE8
   wire pin_sense = pin_reg[8*PS_DIRECTION +: 8] == DIR_INPUT; // RULE8
   wire pin_invert = pin_reg[8*PS_POLARITY +: 8] != POL_LIGHT; // RULE9
   wire master_run = casc_on && is_master;
   wire master_out = master_run && pin_drive
                     && pin_reg[8*PS_OUT_FN +: 8] == OUT_FN_TRIGGER; // RULE10
   wire slave_run = casc_on && !is_master && pin_sense
                    && pin_reg[8*PS_IN_FN +: 8] == IN_FN_TRIGGER; // RULE3 RULE11

   ////////////////////////////////////////////////////////////////////////////
   // microsecond and millisecond time base
   logic [15:0] us_div_reg;
   logic [15:0] ms_div_reg;
   wire us_tick = us_div_reg == 16'(US_DIV - 1);
   wire ms_tick = us_tick && ms_div_reg == 16'(MS_DIV - 1);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         us_div_reg <= 16'h0000;
         ms_div_reg <= 16'h0000;
      end else begin
         us_div_reg <= us_tick ? 16'h0000 : us_div_reg + 16'h0001;
         if (us_tick) ms_div_reg <= (ms_div_reg == 16'(MS_DIV - 1)) ? 16'h0000
                                                                       : ms_div_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master: one trigger per programmed cycle
   logic [15:0] cyc_cnt_reg;
   logic [15:0] pulse_cnt_reg;
   wire master_fire = master_run && ms_tick && cyc_cnt_reg + 16'h0001 >= cycle_ms; // RULE4

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cyc_cnt_reg <= 16'h0000;
         pulse_cnt_reg <= 16'h0000;
      end else begin
         if (!master_run || master_fire) begin
            cyc_cnt_reg <= 16'h0000;
         end else if (ms_tick) begin
            cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
         end
         if (master_fire) begin
            pulse_cnt_reg <= 16'(TRIG_PULSE_US);
         end else if (us_tick && pulse_cnt_reg != 16'h0000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave: synchronise pin and scan_done, then delay and scan
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_prev_reg;
   logic done_meta_reg;
   logic done_sync_reg;
   cts_slave_t slave_reg;
   logic [15:0] dly_cnt_reg;
   logic scan_start_reg;
   logic pin_out_reg;
   logic pin_oe_reg;

   wire pin_level = pin_sync_reg ^ pin_invert; // RULE9
   wire trig_edge = pin_level && !pin_prev_reg;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
         done_meta_reg <= 1'b0;
         done_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= shared_digital_pin_in;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_level;
         done_meta_reg <= scan_done;
         done_sync_reg <= done_meta_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slave_reg <= CTS_IDLE;
         dly_cnt_reg <= 16'h0000;
         scan_start_reg <= 1'b0;
      end else begin
         scan_start_reg <= master_fire; // RULE2
         if (!slave_run) begin
            slave_reg <= CTS_IDLE;
         end else begin
            case (slave_reg)
               CTS_IDLE: begin
                  if (trig_edge) begin // RULE3 RULE11
                     dly_cnt_reg <= delay_us;
                     slave_reg <= CTS_DELAY;
                  end
               end
               CTS_DELAY: begin
                  // edges seen here are ignored
                  if (dly_cnt_reg == 16'h0000) begin // RULE6 RULE16
                     scan_start_reg <= 1'b1;
                     slave_reg <= CTS_SCAN;
                  end else if (us_tick) begin
                     dly_cnt_reg <= dly_cnt_reg - 16'h0001;
                  end
               end
               default: begin
                  if (done_sync_reg) slave_reg <= CTS_IDLE; // RULE16
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared pin drive
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= pin_drive; // RULE8
         pin_out_reg <= (master_out && pulse_cnt_reg != 16'h0000) ^ pin_invert; // RULE9 RULE10
      end
   end

   assign shared_digital_pin_out = pin_out_reg;
   assign shared_digital_pin_oe = pin_oe_reg;
   assign scan_start = scan_start_reg;

endmodule : cts_sync

// file: cts_sync_sva.sv
// cts_sync_sva: port checker for the cascade trigger synchroniser
// assumes it is bound to every cts_sync and sees its ports only
`timescale 1ns/1ps
module cts_sync_sva
   import cts_pkg::*;
#(
   parameter logic [7:0] STATION = 8'h01
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // serial bus
   input wire logic rx_end,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   // pin and scan
   input wire logic shared_digital_pin_out,
   input wire logic shared_digital_pin_oe,
   input wire logic scan_start,
   input wire logic [63:0] cascade_settings,
   input wire logic [31:0] shared_pin_settings
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire logic [7:0] dir = shared_pin_settings[31:24];
   wire logic [7:0] ena = cascade_settings[7:0];

   oe_when_out_a: assert property ($past(rst_b) && $stable(dir) && dir == DIR_OUTPUT
      |-> shared_digital_pin_oe) else $error("pin not driven in output direction");
   oe_when_in_a: assert property ($past(rst_b) && $stable(dir) && dir != DIR_OUTPUT
      |-> !shared_digital_pin_oe) else $error("pin driven while not an output");
   pin_idle_a: assert property ($past(rst_b) && $stable(shared_pin_settings) &&
      shared_pin_settings[7:0] != OUT_FN_TRIGGER |->
      shared_digital_pin_out == (shared_pin_settings[23:16] != POL_LIGHT))
      else $error("idle pin level wrong for polarity");
   reply_head_a: assert property ($rose(tx_valid) |-> tx_byte == STATION && $past(rx_end))
      else $error("reply not opened by station after frame end");
   reply_len_a: assert property ($rose(tx_valid) ##0 tx_ready [*8] |=> !tx_valid)
      else $error("reply longer than eight bytes");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte withdrawn before acceptance");
   cfg_hold_a: assert property (!$past(rx_end) |->
      $stable(cascade_settings) && $stable(shared_pin_settings))
      else $error("settings changed without a frame end");
   scan_pulse_a: assert property (scan_start |=> !scan_start)
      else $error("scan start longer than one cycle");
   scan_enabled_a: assert property (scan_start |-> ena == 8'h01 ||
      $past(ena) == 8'h01 || $past(ena, 2) == 8'h01) else $error("scan while cascade off");
endmodule : cts_sync_sva

bind cts_sync cts_sync_sva #(.STATION(STATION)) cts_sync_sva_inst (.ref_clk, .rst_b,
   .rx_end, .tx_byte, .tx_valid, .tx_ready, .shared_digital_pin_out, .shared_digital_pin_oe,
   .scan_start, .cascade_settings, .shared_pin_settings);

// file: cts_peer.sv
// cts_peer: neighbour curtain on the shared pin and the local scan engine
// assumes the bench steers trig_level; a scan lasts SCAN_CYC clocks
`timescale 1ns/1ps
module cts_peer #(
   parameter int SCAN_CYC = 30
) (
   // clock
   input wire logic ref_clk,
   // shared pin
   input wire logic trig_level,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_in,
   // scan engine
   input wire logic scan_start,
   output logic scan_done
);
   int cnt = 0;
   // the neighbour only drives while this device has let go of the line
   assign pin_in = pin_oe ? pin_out : trig_level;
   always @(posedge ref_clk) begin
      if (scan_start) cnt <= SCAN_CYC + 2;
      else if (cnt > 0) cnt <= cnt - 1;
      scan_done <= (cnt == 1 || cnt == 2);
   end
endmodule : cts_peer

// file: cts_sync_tb.sv
// cts_sync_tb: serial-bus writes, master pacing, slave delayed scan
// assumes US_DIV 4 and MS_DIV 5, so one millisecond is 20 clocks
`timescale 1ns/1ps
module cts_sync_tb;
   import cts_pkg::*;
   logic ref_clk = 0, rst_b = 0, rx_valid = 0, rx_end = 0, tx_ready = 1, trig = 0;
   logic [7:0] rx_byte = 8'h00;
   logic [7:0] tx_byte;
   logic pin_in, pin_out, pin_oe, scan_start, scan_done, tx_valid;
   logic [63:0] cas;
   logic [31:0] pin;
   int num_errors = 0;
   int compares = 0;
   int n, lat, hi;

   cts_sync #(.US_DIV(4), .MS_DIV(5)) cts_sync_inst (.ref_clk, .rst_b, .rx_byte, .rx_valid,
      .rx_end, .tx_byte, .tx_valid, .tx_ready, .shared_digital_pin_in(pin_in),
      .shared_digital_pin_out(pin_out), .shared_digital_pin_oe(pin_oe), .scan_start,
      .scan_done, .cascade_settings(cas), .shared_pin_settings(pin));
   cts_peer cts_peer_inst (.ref_clk, .trig_level(trig), .pin_out, .pin_oe, .pin_in,
      .scan_start, .scan_done);

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////
   // one write frame, then its reply (or its absence when the checksum is spoilt)
   task automatic wr(input logic [15:0] a, input logic [63:0] d, input logic bad,
                     input int stall);
      logic [7:0] q[$];
      logic [55:0] h;
      logic [63:0] got;
      logic [15:0] c;
      int nb, k;
      nb = (a == CASCADE_REG_ADDR) ? 8 : 4;
      h = {8'h01, FN_WRITE_MULTI, a, 8'h00, 8'(nb / 2), 8'(nb)};
      for (int i = 0; i < 7; i++) q.push_back(h[55 - 8 * i -: 8]);
      for (int i = 0; i < nb; i++) q.push_back(d[8 * i +: 8]);
      c = 16'hffff;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      c[0] ^= bad;
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         @(negedge ref_clk);
         rx_valid = 1;
         rx_byte = q[i];
      end
      @(negedge ref_clk);
      rx_valid = 0;
      rx_end = 1;
      tx_ready = (stall == 0);
      @(negedge ref_clk);
      rx_end = 0;
      repeat (stall) @(negedge ref_clk);
      tx_ready = 1;
      k = 0;
      for (int t = 0; t < 40 && k < 8; t++) begin
         if (tx_valid === 1'b1) begin
            got[63 - 8 * k -: 8] = tx_byte;
            k++;
         end
         if (k < 8) @(negedge ref_clk);
      end
      if (bad) begin
         check(k, 0);
      end else begin
         if (k < 8) begin
            num_errors++;
            test_done();
         end else begin
            check(got, (nb == 8) ? 64'h0110_0049_0004_101c : 64'h0110_0051_0002_1019);
         end
      end
      @(negedge ref_clk);
   endtask : wr

   // counts scan pulses and driven-high pin cycles; stop ends at the first pulse
   task automatic scans(input int cyc, input logic stop, output int cnt, output int first,
                        output int hic);
      cnt = 0;
      first = -1;
      hic = 0;
      for (int t = 0; t < cyc && !(stop && cnt > 0); t++) begin
         @(negedge ref_clk);
         hic += (pin_oe === 1'b1 && pin_out === 1'b1);
         if (scan_start === 1'b1) begin
            if (cnt == 0) first = t;
            cnt++;
         end
      end
      if (stop && cnt == 0) begin
         num_errors++;
         test_done();
      end
   endtask : scans

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_b = 1;
      @(negedge ref_clk);
      check(cas, 64'h0);
      check({pin, tx_valid, scan_start}, 64'h0);
      wr(PIN_REG_ADDR, 64'h0000_0003, 0, 3);
      check(pin, 32'h0000_0003);
      // cycle of 3 ms stands for three 1 ms scan times added up
      wr(CASCADE_REG_ADDR, 64'h0003_0000_0000_0101, 0, 0);
      check(cas, 64'h0003_0000_0000_0101);
      scans(200, 1, n, lat, hi);
      scans(120, 0, n, lat, hi);
      check({n, lat}, {32'd2, 32'd59});
      check(hi >= 76 && hi <= 84, 1);
      wr(PIN_REG_ADDR, 64'h0001_0000, 0, 0);
      scans(120, 0, n, lat, hi);
      // inverted polarity: the idle pin is driven high for the whole window
      check({pin_oe, pin_out, hi}, {2'b11, 32'd120});
      wr(PIN_REG_ADDR, 64'h0000_0003, 0, 0);
      wr(CASCADE_REG_ADDR, 64'h0003_0000_0000_0100, 0, 0);
      scans(200, 0, n, lat, hi);
      check({n, hi}, 64'h0);
      wr(PIN_REG_ADDR, 64'h0100_0100, 0, 0);
      check(pin_oe, 0);
      wr(PIN_REG_ADDR, 64'h0000_0003, 1, 0);
      check(pin, 32'h0100_0100);
      // delay of 5 us is the 2 us and 3 us scans of the two curtains ahead
      wr(CASCADE_REG_ADDR, 64'h0003_0000_0005_0001, 0, 0);
      scans(100, 0, n, lat, hi);
      check(n, 0);
      fork
         scans(200, 0, n, lat, hi);
         begin
            trig = 1;
            repeat (4) @(negedge ref_clk);
            trig = 0;
            repeat (6) @(negedge ref_clk);
            trig = 1;
            repeat (4) @(negedge ref_clk);
            trig = 0;
         end
      join
      check(n, 1);
      check(lat >= 20 && lat <= 26, 1);
      // inverted input: line idles high before the trigger function is switched on
      wr(PIN_REG_ADDR, 64'h0101_0000, 0, 0);
      trig = 1;
      wr(PIN_REG_ADDR, 64'h0101_0100, 0, 0);
      fork
         scans(100, 0, n, lat, hi);
         begin
            trig = 0;
            repeat (4) @(negedge ref_clk);
            trig = 1;
         end
      join
      check(n, 1);
      test_done();
   end
endmodule : cts_sync_tb
